/* mucba_key.sv */
`timescale 1ns/1ps
module mucba_key
    import mucba_pkg::*;
#(
    parameter int unsigned LONG_CYC = MUCBA_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic key_i,
    output logic short_o,
    output logic long_o
);
    logic [31:0] hold;
    logic [31:0] next_hold;
    logic next_short;
    logic next_long;

    // Short on release before limit, long once when limit reached
    always_comb begin
        next_short = 1'b0;
        next_long = 1'b0;
        next_hold = hold;
        if (key_i) begin
            if (hold != LONG_CYC) begin
                next_hold = hold + 32'h0000_0001;
            end
            next_long = (hold == LONG_CYC - 1);
        end else begin
            next_short = (hold != 32'h0000_0000) && (hold < LONG_CYC);
            next_hold = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold <= 32'h0000_0000;
            short_o <= 1'b0;
            long_o <= 1'b0;
        end else if (ce_i) begin
            hold <= next_hold;
            short_o <= next_short;
            long_o <= next_long;
        end
    end
endmodule // mucba_key

/* mucba_operator.sv */
`timescale 1ns/1ps
module mucba_operator (
    input wire logic clk_i,
    output logic cal_key_o,
    output logic reset_key_o
);
    // Keys rest released
    initial begin
        cal_key_o = 1'b0;
        reset_key_o = 1'b0;
    end
    // Hold chosen keys n cycles, release, settle, return mid-cycle
    task automatic press(input logic c, input logic r, input int n);
        @(posedge clk_i);
        cal_key_o <= c;
        reset_key_o <= r;
        repeat (n) @(posedge clk_i);
        cal_key_o <= 1'b0;
        reset_key_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
endmodule // mucba_operator

/* mucba_pkg.sv */
package mucba_pkg;
    // Unit pairings, partial over totals
    typedef enum logic [1:0] {
        MUCBA_UNIT_L_L,
        MUCBA_UNIT_G_G,
        MUCBA_UNIT_Q_G,
        MUCBA_UNIT_P_G
    } mucba_unit_t;

    localparam logic [1:0] MUCBA_UNIT_LAST = 2'h3;
    localparam int unsigned MUCBA_CLK_HZ = 10_000_000;
    // Key, idle, start and blink timing in milliseconds
    localparam int unsigned MUCBA_LONG_MS = 1000;
    localparam int unsigned MUCBA_IDLE_MS = 5000;
    localparam int unsigned MUCBA_START_MS = 2000;
    localparam int unsigned MUCBA_BLINK_MS = 500;
    localparam int unsigned MUCBA_LONG_CYC = MUCBA_CLK_HZ / 1000 * MUCBA_LONG_MS;
    localparam int unsigned MUCBA_IDLE_CYC = MUCBA_CLK_HZ / 1000 * MUCBA_IDLE_MS;
    localparam int unsigned MUCBA_START_CYC =
        MUCBA_CLK_HZ / 1000 * MUCBA_START_MS;
    localparam int unsigned MUCBA_BLINK_CYC =
        MUCBA_CLK_HZ / 1000 * MUCBA_BLINK_MS;
    localparam int unsigned MUCBA_CNT_W = 32;

    // Volume scale per unit, in millilitres per count
    localparam logic [31:0] MUCBA_ML_LITRE = 32'h0000_03E8;
    localparam logic [31:0] MUCBA_ML_GALLON = 32'h0000_0EC9;
    localparam logic [31:0] MUCBA_ML_QUART = 32'h0000_03B2;
    localparam logic [31:0] MUCBA_ML_PINT = 32'h0000_01D9;
endpackage

/* mucba_properties.sv */
`timescale 1ns/1ps
module mucba_properties
    import mucba_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire mucba_pkg::mucba_unit_t unit_o,
    input wire mucba_pkg::mucba_unit_t disp_unit_o,
    input wire logic menu_banner_o,
    input wire logic standby_o,
    input wire logic count_enable_o,
    input wire logic starting_o,
    input wire logic batt_icon_o,
    input wire logic blank_o,
    input wire logic store_o,
    input wire logic [15:0] cal_factor_o
);
    // One clock domain, reset disables all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_blank_latch; blank_o |=> blank_o; endproperty
    a_blank_latch: assert property (p_blank_latch)
        else $error("blank dropped before reset");
    property p_blank_inhibit;
        blank_o |-> !count_enable_o && !menu_banner_o && !standby_o;
    endproperty
    a_blank_inhibit: assert property (p_blank_inhibit)
        else $error("operation not inhibited when blank");
    property p_blank_flash;
        blank_o |-> ##[1:9] (batt_icon_o != $past(batt_icon_o));
    endproperty
    a_blank_flash: assert property (p_blank_flash)
        else $error("battery icon not flashing");
    property p_store_pulse; store_o |=> !store_o; endproperty
    a_store_pulse: assert property (p_store_pulse)
        else $error("store longer than one cycle");
    property p_store_start; store_o |-> ##[0:2] starting_o; endproperty
    a_store_start: assert property (p_store_start)
        else $error("no start cycle after store");
    property p_cal_kept;
        store_o |=> cal_factor_o == $past(cal_factor_o, 2);
    endproperty
    a_cal_kept: assert property (p_cal_kept)
        else $error("cal factor changed by unit store");
    property p_menu_entry; $rose(menu_banner_o) |-> $past(standby_o);
    endproperty
    a_menu_entry: assert property (p_menu_entry)
        else $error("menu entered outside standby");
    property p_menu_show; $rose(menu_banner_o) |-> disp_unit_o == unit_o;
    endproperty
    a_menu_show: assert property (p_menu_show)
        else $error("menu does not show current unit");
    property p_step;
        menu_banner_o && $past(menu_banner_o)
            && disp_unit_o != $past(disp_unit_o)
            |-> disp_unit_o == 2'($past(disp_unit_o) + 2'h1);
    endproperty
    a_step: assert property (p_step)
        else $error("candidate did not step by one");
    property p_unit_hold;
        unit_o != $past(unit_o) |-> store_o || starting_o;
    endproperty
    a_unit_hold: assert property (p_unit_hold)
        else $error("unit changed without store");
    property p_idle_out;
        standby_o |-> count_enable_o && !menu_banner_o;
    endproperty
    a_idle_out: assert property (p_idle_out)
        else $error("standby not ready to count");
endmodule // mucba_properties

bind mucba_top mucba_properties i_props (.clk_i(clk_i), .reset_i(reset_i),
    .unit_o(unit_o), .disp_unit_o(disp_unit_o),
    .menu_banner_o(menu_banner_o), .standby_o(standby_o),
    .count_enable_o(count_enable_o), .starting_o(starting_o),
    .batt_icon_o(batt_icon_o), .blank_o(blank_o), .store_o(store_o),
    .cal_factor_o(cal_factor_o));

/* mucba_sync.sv */
`timescale 1ns/1ps
module mucba_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    // Accept a change once stages two and three agree
    always_comb begin
        next_q = (s2 == s3) ? s3 : q_o;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= next_q;
        end
    end
endmodule // mucba_sync

/* mucba_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - Four unit pairings: L/L, G/G, Q/G, P/G
// - Menu entry only in standby, both keys
// - Menu shows banner and current pairing
// - Short reset press advances candidate pairing
// - Long cal press stores, restarts, counts
// - Stored change converts both totals
// - Calibration factor unchanged by unit change
// - Level one: steady icon, keep working
// - Level two: inhibit, blank, flash icon
// - Power up runs without operator action
// - Counters retained across power loss
// - Calibration factor retained across power loss
// - Standby after idle until key or flow
module mucba_top
    import mucba_pkg::*;
#(
    parameter int unsigned LONG_CYC = MUCBA_LONG_CYC,
    parameter int unsigned IDLE_CYC = MUCBA_IDLE_CYC,
    parameter int unsigned START_CYC = MUCBA_START_CYC,
    parameter int unsigned BLINK_CYC = MUCBA_BLINK_CYC,
    parameter int unsigned CNT_W = MUCBA_CNT_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic cal_key_i,
    input wire logic reset_key_i,
    input wire logic flow_active_i,
    input wire logic batt_low1_i,
    input wire logic batt_low2_i,
    input wire logic [1:0] nv_unit_i,
    input wire logic [CNT_W-1:0] nv_reset_total_i,
    input wire logic [CNT_W-1:0] nv_general_total_i,
    input wire logic [CNT_W-1:0] nv_partial_i,
    input wire logic [15:0] nv_cal_factor_i,
    input wire logic [CNT_W-1:0] partial_i,
    input wire logic [CNT_W-1:0] reset_total_i,
    input wire logic [CNT_W-1:0] general_total_i,
    output mucba_pkg::mucba_unit_t unit_o,
    output mucba_pkg::mucba_unit_t disp_unit_o,
    output logic menu_banner_o,
    output logic standby_o,
    output logic count_enable_o,
    output logic starting_o,
    output logic batt_icon_o,
    output logic blank_o,
    output logic store_o,
    output logic [CNT_W-1:0] partial_o,
    output logic [CNT_W-1:0] reset_total_o,
    output logic [CNT_W-1:0] general_total_o,
    output logic [15:0] cal_factor_o
);
    import mucba_pkg::*;

    // Controller states
    typedef enum logic [2:0] {
        ST_RESTORE,
        ST_START,
        ST_ACTIVE,
        ST_STANDBY,
        ST_MENU,
        ST_CONVERT,
        ST_DEAD
    } mucba_state_t;

    // Synchronised pins and key events
    logic cal_s;
    logic rst_s;
    logic flow_s;
    logic low1_s;
    logic low2_s;
    logic cal_short;
    logic cal_long;
    logic rst_short;
    logic rst_long;

    // Pin synchronisers
    mucba_sync u_sync_cal (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .d_i(cal_key_i), .q_o(cal_s));
    mucba_sync u_sync_rst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .d_i(reset_key_i), .q_o(rst_s));
    mucba_sync u_sync_flow (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .d_i(flow_active_i), .q_o(flow_s));
    mucba_sync u_sync_low1 (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .d_i(batt_low1_i), .q_o(low1_s));
    mucba_sync u_sync_low2 (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .d_i(batt_low2_i), .q_o(low2_s));

    // Short and long press classifiers
    mucba_key #(.LONG_CYC(LONG_CYC)) u_key_cal (.clk_i(clk_i),
        .reset_i(reset_i), .ce_i(ce_i), .key_i(cal_s),
        .short_o(cal_short), .long_o(cal_long));
    mucba_key #(.LONG_CYC(LONG_CYC)) u_key_rst (.clk_i(clk_i),
        .reset_i(reset_i), .ce_i(ce_i), .key_i(rst_s),
        .short_o(rst_short), .long_o(rst_long));

    // Sequencer state
    mucba_state_t state;
    mucba_state_t next_state;
    mucba_unit_t cand;
    mucba_unit_t next_cand;
    mucba_unit_t next_unit;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [31:0] blink;
    logic [31:0] next_blink;
    logic flash;
    logic next_flash;
    logic menu_armed;
    logic next_menu_armed;
    logic menu_up;
    logic next_menu_up;
    logic [CNT_W-1:0] next_partial;
    logic [CNT_W-1:0] next_reset_total;
    logic [CNT_W-1:0] next_general_total;
    logic [15:0] next_cal_factor;
    logic next_store;

    // Volume per count of a totals unit
    // four pairings mapped
    function automatic logic [31:0] tot_scale(input mucba_unit_t u);
        tot_scale = (u == MUCBA_UNIT_L_L) ? MUCBA_ML_LITRE : MUCBA_ML_GALLON;
    endfunction

    // Re-express a total from old unit into new unit
    function automatic logic [CNT_W-1:0] convert(
        input logic [CNT_W-1:0] v,
        input mucba_unit_t from_u,
        input mucba_unit_t to_u
    );
        logic [CNT_W+31:0] prod;
        prod = {32'h0000_0000, v} * {{CNT_W{1'b0}}, tot_scale(from_u)};
        convert = CNT_W'(prod / {{CNT_W{1'b0}}, tot_scale(to_u)});
    endfunction

    // Main control sequencing
    always_comb begin
        next_state = state;
        next_cand = cand;
        next_unit = unit_o;
        next_timer = timer;
        next_menu_armed = menu_armed;
        next_menu_up = menu_up;
        next_partial = partial_o;
        next_reset_total = reset_total_o;
        next_general_total = general_total_o;
        next_cal_factor = cal_factor_o;
        next_store = 1'b0;
        unique case (state)
            ST_RESTORE: begin
                next_unit = mucba_unit_t'(nv_unit_i);
                next_partial = nv_partial_i;
                next_reset_total = nv_reset_total_i;
                next_general_total = nv_general_total_i;
                next_cal_factor = nv_cal_factor_i;
                next_timer = 32'h0000_0000;
                next_state = ST_START;
            end
            ST_START: begin
                next_timer = timer + 32'h0000_0001;
                if (timer >= START_CYC - 1) begin
                    next_timer = 32'h0000_0000;
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                next_partial = partial_i;
                next_reset_total = reset_total_i;
                next_general_total = general_total_i;
                next_timer = timer + 32'h0000_0001;
                if (flow_s || cal_s || rst_s) begin
                    next_timer = 32'h0000_0000;
                end else if (timer >= IDLE_CYC - 1) begin
                    next_timer = 32'h0000_0000;
                    next_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                next_partial = partial_i;
                next_reset_total = reset_total_i;
                next_general_total = general_total_i;
                if (cal_s && rst_s) begin
                    next_cand = unit_o;
                    next_menu_armed = 1'b0;
                    next_menu_up = 1'b0;
                    next_state = ST_MENU;
                // wake on flow or lone press
                end else if (flow_s || cal_short || rst_short || cal_long
                        || rst_long) begin
                    next_timer = 32'h0000_0000;
                    next_state = ST_ACTIVE;
                end
            end
            ST_MENU: begin
                // Ignore the entry chord and its release pulse
                if (!cal_s && !rst_s) begin
                    next_menu_up = 1'b1;
                    next_menu_armed = menu_up;
                end
                if (menu_armed && rst_short) begin
                    next_cand = (cand == mucba_unit_t'(MUCBA_UNIT_LAST)) ?
                        MUCBA_UNIT_L_L : mucba_unit_t'(cand + 2'h1);
                end
                if (menu_armed && cal_long) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                next_reset_total = convert(reset_total_o, unit_o, cand);
                next_general_total = convert(general_total_o, unit_o, cand);
                next_unit = cand;
                next_store = 1'b1;
                next_cal_factor = cal_factor_o;
                next_timer = 32'h0000_0000;
                next_state = ST_START;
            end
            ST_DEAD: begin
                next_state = ST_DEAD;
            end
            default: begin
                next_state = ST_RESTORE;
            end
        endcase
        if (low2_s) begin
            next_state = ST_DEAD;
        end
    end

    // Icon blink timer
    always_comb begin
        next_blink = blink + 32'h0000_0001;
        next_flash = flash;
        if (blink >= BLINK_CYC - 1) begin
            next_blink = 32'h0000_0000;
            next_flash = !flash;
        end
    end

    // Register all state, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_RESTORE;
            cand <= MUCBA_UNIT_L_L;
            unit_o <= MUCBA_UNIT_L_L;
            timer <= 32'h0000_0000;
            menu_armed <= 1'b0;
            menu_up <= 1'b0;
            partial_o <= '0;
            reset_total_o <= '0;
            general_total_o <= '0;
            cal_factor_o <= 16'h0000;
            store_o <= 1'b0;
            blink <= 32'h0000_0000;
            flash <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            cand <= next_cand;
            unit_o <= next_unit;
            timer <= next_timer;
            menu_armed <= next_menu_armed;
            menu_up <= next_menu_up;
            partial_o <= next_partial;
            reset_total_o <= next_reset_total;
            general_total_o <= next_general_total;
            cal_factor_o <= next_cal_factor;
            store_o <= next_store;
            blink <= next_blink;
            flash <= next_flash;
        end
    end

    // Display and status outputs
    // banner with current pairing
    assign menu_banner_o = (state == ST_MENU);
    assign disp_unit_o = (state == ST_MENU) ? cand : unit_o;
    assign standby_o = (state == ST_STANDBY);
    assign starting_o = (state == ST_START) || (state == ST_RESTORE);
    assign count_enable_o = (state == ST_ACTIVE) || (state == ST_STANDBY);
    assign blank_o = (state == ST_DEAD);
    assign batt_icon_o = (state == ST_DEAD) ? flash : low1_s;
endmodule // mucba_top

/* mucba_top_bench.sv */
`timescale 1ns/1ps
module mucba_top_bench;
    import mucba_pkg::*;
    localparam int unsigned START = 10;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic flow = 1'b0;
    logic low1 = 1'b0;
    logic low2 = 1'b0;
    logic [31:0] rt_i = 32'h0000_03E8;
    logic [31:0] gt_i = 32'h0000_07D0;
    logic [31:0] pt_i = 32'h0000_0012;
    logic [15:0] cal_i = 16'h03F1;
    logic ce = 1'b1;
    logic [1:0] nv_u = 2'h1;
    logic ck, rk, banner, stby, cnt_en, start, icon, blank, store;
    mucba_unit_t unit, disp, snap_u;
    logic [31:0] pt, rt, gt, snap_rt, snap_gt;
    logic [15:0] cal;
    int num_errors = 0;
    int checks_done = 0;
    int n_store = 0;

    always #50 clk_i = ~clk_i;

    mucba_operator i_op (.clk_i(clk_i), .cal_key_o(ck), .reset_key_o(rk));
    mucba_top #(.LONG_CYC(8), .IDLE_CYC(20), .START_CYC(START),
        .BLINK_CYC(4), .CNT_W(32)) i_dut (.clk_i(clk_i),
        .reset_i(reset_i), .ce_i(ce), .cal_key_i(ck),
        .reset_key_i(rk), .flow_active_i(flow), .batt_low1_i(low1),
        .batt_low2_i(low2), .nv_unit_i(nv_u), .nv_reset_total_i(rt_i),
        .nv_general_total_i(gt_i), .nv_partial_i(pt_i),
        .nv_cal_factor_i(cal_i), .partial_i(pt_i), .reset_total_i(rt_i),
        .general_total_i(gt_i), .unit_o(unit), .disp_unit_o(disp),
        .menu_banner_o(banner), .standby_o(stby), .count_enable_o(cnt_en),
        .starting_o(start), .batt_icon_o(icon), .blank_o(blank),
        .store_o(store), .partial_o(pt), .reset_total_o(rt),
        .general_total_o(gt), .cal_factor_o(cal));

    // Capture values in the store cycle
    always @(posedge clk_i) begin
        if (store === 1'b1) begin
            n_store <= n_store + 1;
            snap_u <= unit;
            snap_rt <= rt;
            snap_gt <= gt;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic t_restore();
        tick(3);
        chk("starting", start, 1);
        chk("partial", pt, pt_i);
        chk("reset_total", rt, rt_i);
        chk("general_total", gt, gt_i);
        chk("unit", unit, 1);
        chk("cal_factor", cal, cal_i);
        tick(START);
        chk("starting", start, 0);
        chk("count_enable", cnt_en, 1);
    endtask

    task automatic t_busy();
        @(posedge clk_i) flow <= 1'b1;
        tick(25);
        i_op.press(1, 1, 6);
        chk("banner", banner, 0);
        chk("standby", stby, 0);
        @(posedge clk_i) flow <= 1'b0;
        tick(30);
        chk("standby", stby, 1);
        i_op.press(0, 1, 3);
        chk("standby", stby, 0);
        tick(25);
        chk("standby", stby, 1);
    endtask

    task automatic t_menu();
        i_op.press(1, 1, 6);
        chk("banner", banner, 1);
        chk("cand", disp, 1);
        for (int k = 0; k < 3; k++) begin
            i_op.press(0, 1, 3);
            chk("cand", disp, 32'((k + 2) % 4));
        end
        i_op.press(1, 0, 16);
        chk("stores", n_store, 1);
        chk("stored_unit", snap_u, 0);
        chk("conv_rt", snap_rt, 1000 * MUCBA_ML_GALLON / MUCBA_ML_LITRE);
        chk("conv_gt", snap_gt, 2000 * MUCBA_ML_GALLON / MUCBA_ML_LITRE);
        chk("cal_factor", cal, cal_i);
        tick(START + 4);
        chk("starting", start, 0);
        chk("count_enable", cnt_en, 1);
        chk("unit", unit, 0);
    endtask

    task automatic t_battery();
        int flips;
        logic prev;
        flips = 0;
        @(posedge clk_i) low1 <= 1'b1;
        tick(8);
        chk("icon", icon, 1);
        chk("blank", blank, 0);
        chk("count_enable", cnt_en, 1);
        tick(5);
        chk("icon_steady", icon, 1);
        @(posedge clk_i) low2 <= 1'b1;
        tick(8);
        chk("blank", blank, 1);
        chk("count_enable", cnt_en, 0);
        prev = icon;
        repeat (12) begin
            tick(1);
            if (icon !== prev) flips++;
            prev = icon;
        end
        chk("flash", 32'(flips > 1), 1);
    endtask

    // Power loss while blanked at level two, with new retained values, start frozen a while
    task automatic t_power();
        @(posedge clk_i) begin
            reset_i <= 1'b1;
            low1 <= 1'b0;
            low2 <= 1'b0;
            nv_u <= 2'h3;
            rt_i <= 32'h0000_0BB8;
            cal_i <= 16'h0400;
        end
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        ce <= 1'b0;
        tick(20);
        chk("frozen_start", start, 1);
        chk("frozen_unit", unit, 0);
        @(posedge clk_i) ce <= 1'b1;
        tick(3);
        chk("blank", blank, 0);
        chk("unit", unit, 3);
        chk("reset_total", rt, 32'h0000_0BB8);
        chk("cal_factor", cal, 16'h0400);
        tick(START);
        chk("count_enable", cnt_en, 1);
        chk("icon", icon, 0);
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        t_restore();
        t_busy();
        t_menu();
        t_battery();
        t_power();
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
endmodule // mucba_top_bench
